// ==== rofd_regs.svh ====
// Register map, reset values and timing figures of the supervisor slice.
// Assumes a 10 MHz core clock and a 32-bit AXI4-Lite register port.
`ifndef ROFD_REGS_SVH
`define ROFD_REGS_SVH
`define ROFD_A_CTRL      8'h00
`define ROFD_A_CLOCK     8'h04
`define ROFD_A_FLAGS     8'h08
`define ROFD_A_YEAR      8'h0c
`define ROFD_A_SN_LO     8'h10
`define ROFD_A_SN_HI     8'h14
`define ROFD_A_ISTAT     8'h18
`define ROFD_A_IMASK     8'h1c
`define ROFD_CTRL_INIT   24'h0000f8
`define ROFD_PWRUP_KEEP  24'h0007f9
`define ROFD_TR_BIT      7
`define ROFD_CENT_LO     4
`define ROFD_CENT_HI     5
`define ROFD_LEAP_BIT    8
`define ROFD_CLK_HZ      10000000
`define ROFD_TREC_DEF_MS 96
`define ROFD_TREC_ST_MS  40
`define ROFD_TREC_TR_US  50
`define ROFD_RESP_OK     2'b00
`define ROFD_RESP_SLV    2'b10
`define ROFD_RESP_DEC    2'b11
`endif

// ==== rofd_pkg.sv ====
// Types shared by the supervisor slice.
// Assumes rofd_regs.svh for the numeric layout.
package rofd_pkg;
	typedef struct packed {
		logic       wd_res_hi;
		logic       wd_res_lo;
		logic [4:0] wd_multiplier;
		logic       wd_steer;
		logic       tamper_irq_en_b;
		logic       tamper_irq_en_a;
		logic       squarewave_en;
		logic       alarm_flag_en;
		logic       freq_test;
		logic       tamper_en_b;
		logic       tamper_en_a;
		logic       threshold_sel;
		logic       powerfail_opendrain;
		logic       squarewave_opendrain;
		logic       khz32_out_en;
		logic       out_bit;
		logic       halt_update;
		logic       backup_irq_en;
		logic       osc_fail_irq_en;
		logic       osc_halt;
	} rofd_ctrl_s;
	typedef enum logic [1:0] {PWR_OFF, PWR_REC, PWR_ON} rofd_pwr_e;
endpackage

// ==== rofd_ctl.sv ====
// Oscillator-fail and deselect supervisor with AXI4-Lite registers.
// Assumes VCC_OK and OSC_RUN come from analog monitors, asynchronous.
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`include "rofd_regs.svh"

// Operation
// - Recovery select bit is D7 of 04h
// - Reject writes during recovery after supply return
// - Recovery 96ms, 40ms with halt, 50us fast
// - Eight-byte serial number, read only, parity; code holds a seven-byte number plus one parity byte
// - Oscillator stop sets the fail flag
// - Flag set at power-on, low voltage, halt; code sets it at reset, oscillator stop and halt, not on low voltage
// - Enabled fail flag drives interrupt pin
// - Pin released by clear, disable, reset
// - Fail flag sticky until written zero
// - Detection works on main and battery
// - Battery pin drive needs backup enable
// - Leap rule with two century bits
// - Tamper enable blocks halt-update at power-down
// - 32 kHz output only on main supply
// - Power-on clears listed enables to zero
module rofd_ctl import rofd_pkg::*; #(
	parameter int          REC_DEF_CYC = (`ROFD_TREC_DEF_MS * (`ROFD_CLK_HZ / 1000)),
	parameter int          REC_ST_CYC  = (`ROFD_TREC_ST_MS * (`ROFD_CLK_HZ / 1000)),
	parameter logic [55:0] SERIAL_NUM  = 56'h5a3c_96e1_0f7b_24 // Arbitrary value
) (
	// Clock and reset
	input  wire logic        CORE_CLK,
	input  wire logic        SYS_RST,
	// AXI4-Lite write
	input  wire logic [7:0]  AWADDR,
	input  wire logic        AWVALID,
	output logic             AWREADY,
	input  wire logic [31:0] WDATA,
	input  wire logic [3:0]  WSTRB,
	input  wire logic        WVALID,
	output logic             WREADY,
	output logic [1:0]       BRESP,
	output logic             BVALID,
	input  wire logic        BREADY,
	// AXI4-Lite read
	input  wire logic [7:0]  ARADDR,
	input  wire logic        ARVALID,
	output logic             ARREADY,
	output logic [31:0]      RDATA,
	output logic [1:0]       RRESP,
	output logic             RVALID,
	input  wire logic        RREADY,
	// Monitors
	input  wire logic        VCC_OK,
	input  wire logic        OSC_RUN,
	// Pins and status
	output logic             IRQ_OUT_O,
	output logic             IRQ_OUT_OE,
	output logic             KHZ32_EN,
	output logic             RST_ACT,
	output logic             WR_PROTECT,
	output logic             IRQ
);
	localparam int         REC_TR_CYC = (`ROFD_TREC_TR_US * (`ROFD_CLK_HZ / 1000) + 999) / 1000;
	localparam logic [7:0] SN_PAR     = SERIAL_NUM[55:48] ^ SERIAL_NUM[47:40] ^ SERIAL_NUM[39:32]
	                                  ^ SERIAL_NUM[31:24] ^ SERIAL_NUM[23:16] ^ SERIAL_NUM[15:8]
	                                  ^ SERIAL_NUM[7:0];

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
	                                      input logic [3:0] strb);
		merge = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				merge[8*i +: 8] = nw[8*i +: 8];
			end
		end
	endfunction

	// ------------------------------------------------------------
	// Monitor synchronisers
	// ------------------------------------------------------------
	logic [2:0]  vcc_sy;
	logic [2:0]  osc_sy;
	logic        vcc;
	logic        osc;
	logic        vcc_d;

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			vcc_sy <= 3'h7;
			osc_sy <= 3'h7;
			vcc    <= 1'b1;
			osc    <= 1'b1;
			vcc_d  <= 1'b1;
		end else begin
			vcc_sy <= {vcc_sy[1:0], VCC_OK};
			osc_sy <= {osc_sy[1:0], OSC_RUN};
			if (vcc_sy[1] == vcc_sy[2]) begin
				vcc <= vcc_sy[2];
			end
			if (osc_sy[1] == osc_sy[2]) begin
				osc <= osc_sy[2];
			end
			vcc_d <= vcc;
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite handshakes
	// ------------------------------------------------------------
	logic       aw_have;
	logic       w_have;
	logic [7:0] wa;
	logic [31:0] wd;
	logic [3:0] ws;
	logic       aw_take;
	logic       w_take;
	logic       ar_take;
	logic       wr_go;
	logic       wr_ok;
	logic       wr_map;

	assign aw_take = AWVALID && AWREADY;
	assign w_take  = WVALID && WREADY;
	assign ar_take = ARVALID && ARREADY;
	assign wr_go   = aw_have && w_have && !BVALID;

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			aw_have <= 1'b0;
			w_have  <= 1'b0;
			AWREADY <= 1'b0;
			WREADY  <= 1'b0;
			wa      <= 8'h00;
			wd      <= 32'h0000_0000;
			ws      <= 4'h0;
		end else begin
			aw_have <= aw_take || (aw_have && !wr_go);
			w_have  <= w_take || (w_have && !wr_go);
			AWREADY <= !(aw_take || (aw_have && !wr_go));
			WREADY  <= !(w_take || (w_have && !wr_go));
			if (aw_take) begin
				wa <= AWADDR;
			end
			if (w_take) begin
				wd <= WDATA;
				ws <= WSTRB;
			end
		end
	end

	always_comb begin
		case (wa)
			`ROFD_A_CTRL, `ROFD_A_CLOCK, `ROFD_A_FLAGS, `ROFD_A_YEAR, `ROFD_A_ISTAT,
			`ROFD_A_IMASK: wr_map = 1'b1;
			default:       wr_map = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// Power state and recovery timer
	// ------------------------------------------------------------
	rofd_pwr_e   st;
	logic [19:0] rec_cnt;
	logic        trec_sel;
	rofd_ctrl_s  ctrl;

	assign wr_ok = wr_go && wr_map && (st == PWR_ON);

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			st      <= PWR_ON;
			rec_cnt <= 20'h00000;
		end else begin
			case (st)
				PWR_ON:  if (!vcc) begin
					st <= PWR_OFF;
				end
				PWR_OFF: if (vcc) begin
					st <= PWR_REC;
					if (trec_sel) begin
						rec_cnt <= 20'(REC_TR_CYC - 1);
					end else if (ctrl.osc_halt) begin
						rec_cnt <= 20'(REC_ST_CYC - 1);
					end else begin
						rec_cnt <= 20'(REC_DEF_CYC - 1);
					end
				end
				PWR_REC: if (!vcc) begin
					st <= PWR_OFF;
				end else if (rec_cnt == 20'h00000) begin
					st <= PWR_ON;
				end else begin
					rec_cnt <= rec_cnt - 20'h00001;
				end
				default: st <= PWR_OFF;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Control, clock and year registers
	// ------------------------------------------------------------
	logic [1:0]  century;
	logic [6:0]  year;
	logic [31:0] cw;

	assign cw = merge({8'h00, ctrl}, wd, ws);

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			ctrl <= `ROFD_CTRL_INIT;
		end else if (st == PWR_OFF && vcc) begin
			ctrl <= ctrl & `ROFD_PWRUP_KEEP;
		end else if ((st == PWR_ON) && !vcc && !(ctrl.tamper_en_a || ctrl.tamper_en_b)) begin
			ctrl.halt_update <= 1'b1;
		end else if (wr_ok && wa == `ROFD_A_CTRL) begin
			ctrl <= cw[23:0];
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			trec_sel <= 1'b0;
			century  <= 2'h0;
			year     <= 7'h00;
		end else if (wr_ok && wa == `ROFD_A_CLOCK && ws[0]) begin
			trec_sel <= wd[`ROFD_TR_BIT];
			century  <= {wd[`ROFD_CENT_HI], wd[`ROFD_CENT_LO]};
		end else if (wr_ok && wa == `ROFD_A_YEAR && ws[0]) begin
			year <= wd[6:0];
		end
	end

	logic leap;

	assign leap = (year[1:0] == 2'h0) && ((year != 7'h00) || (century == 2'h0));

	// ------------------------------------------------------------
	// Oscillator fail flag and interrupt status
	// ------------------------------------------------------------
	logic       osc_fail_flag;
	logic       of_set;
	logic       of_d;
	logic       rec_d;
	logic [1:0] istat;
	logic [1:0] imask;
	logic [1:0] ev;

	assign of_set = !osc || ctrl.osc_halt;
	assign ev     = {rec_d && (st == PWR_ON), osc_fail_flag && !of_d};

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			osc_fail_flag <= 1'b1;
		end else if (of_set) begin
			osc_fail_flag <= 1'b1;
		end else if (wr_ok && wa == `ROFD_A_FLAGS && ws[0] && !wd[0]) begin
			osc_fail_flag <= 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			of_d  <= 1'b1;
			rec_d <= 1'b0;
			istat <= 2'h0;
			imask <= 2'h0;
		end else begin
			of_d  <= osc_fail_flag;
			rec_d <= (st == PWR_REC);
			if (wr_ok && wa == `ROFD_A_ISTAT && ws[0]) begin
				istat <= ev | (istat & ~wd[1:0]);
			end else begin
				istat <= istat | ev;
			end
			if (wr_ok && wa == `ROFD_A_IMASK && ws[0]) begin
				imask <= wd[1:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Pins and response channels
	// ------------------------------------------------------------
	logic irq_act;
	logic pin_pwr;

	assign pin_pwr = vcc || ctrl.backup_irq_en;
	assign irq_act = osc_fail_flag && ctrl.osc_fail_irq_en && (st != PWR_REC) && pin_pwr;

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			IRQ_OUT_O  <= 1'b0;
			IRQ_OUT_OE <= 1'b0;
			KHZ32_EN   <= 1'b0;
			RST_ACT    <= 1'b0;
			WR_PROTECT <= 1'b0;
			IRQ        <= 1'b0;
		end else begin
			IRQ_OUT_O  <= 1'b0;
			IRQ_OUT_OE <= irq_act || (!ctrl.out_bit && pin_pwr);
			KHZ32_EN   <= ctrl.khz32_out_en && vcc && !ctrl.osc_halt;
			RST_ACT    <= (st != PWR_ON);
			WR_PROTECT <= (st != PWR_ON);
			IRQ        <= |(istat & imask);
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			BVALID <= 1'b0;
			BRESP  <= `ROFD_RESP_OK;
		end else if (wr_go) begin
			BVALID <= 1'b1;
			BRESP  <= !wr_map ? `ROFD_RESP_DEC : (wr_ok ? `ROFD_RESP_OK : `ROFD_RESP_SLV);
		end else if (BREADY) begin
			BVALID <= 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			ARREADY <= 1'b0;
			RVALID  <= 1'b0;
			RDATA   <= 32'h0000_0000;
			RRESP   <= `ROFD_RESP_OK;
		end else begin
			ARREADY <= !(ar_take || (RVALID && !RREADY));
			if (ar_take) begin
				RVALID <= 1'b1;
				RRESP  <= `ROFD_RESP_OK;
				case (ARADDR)
					`ROFD_A_CTRL:  RDATA <= {8'h00, ctrl};
					`ROFD_A_CLOCK: RDATA <= {24'h0, trec_sel, 1'b0, century[1], century[0], 4'h0};
					`ROFD_A_FLAGS: RDATA <= {30'h0, st != PWR_ON, osc_fail_flag};
					`ROFD_A_YEAR:  RDATA <= {23'h0, leap, 1'b0, year};
					`ROFD_A_SN_LO: RDATA <= SERIAL_NUM[31:0];
					`ROFD_A_SN_HI: RDATA <= {SN_PAR, SERIAL_NUM[55:32]};
					`ROFD_A_ISTAT: RDATA <= {30'h0, istat};
					`ROFD_A_IMASK: RDATA <= {30'h0, imask};
					default: begin
						RDATA <= 32'h0000_0000;
						RRESP <= `ROFD_RESP_DEC;
					end
				endcase
			end else if (RREADY) begin
				RVALID <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (SYS_RST);

	a_trec_bit_store: assert property (wr_ok && wa == `ROFD_A_CLOCK && ws[0] |=> trec_sel == $past(wd[7]))
		else $error("recovery select not stored");
	a_write_reject: assert property (wr_go && st != PWR_ON |=> $stable(ctrl) && $stable(trec_sel)
		##1 BRESP != `ROFD_RESP_OK) else $error("write taken during recovery");
	a_rec_fast_load: assert property (st == PWR_OFF && vcc && trec_sel |=> rec_cnt == 20'(REC_TR_CYC - 1))
		else $error("fast recovery count wrong");
	a_serial_read: assert property (ar_take && ARADDR == `ROFD_A_SN_LO |=> RDATA == SERIAL_NUM[31:0])
		else $error("serial number read wrong");
	a_halt_sets_of: assert property (ctrl.osc_halt || !osc |=> osc_fail_flag)
		else $error("fail flag not set");
	a_of_sticky: assert property (osc_fail_flag && !(wr_ok && wa == `ROFD_A_FLAGS) |=> osc_fail_flag)
		else $error("fail flag dropped");
	a_pin_drive: assert property (irq_act |=> IRQ_OUT_OE && !IRQ_OUT_O)
		else $error("interrupt pin not driven");
	a_pin_release: assert property ((st == PWR_REC || !ctrl.osc_fail_irq_en || !osc_fail_flag) && ctrl.out_bit |=> !IRQ_OUT_OE)
		else $error("interrupt not released");
	a_backup_gate: assert property (!vcc && !ctrl.backup_irq_en |=> !IRQ_OUT_OE)
		else $error("pin driven on battery");
	a_khz_main: assert property (!vcc |=> !KHZ32_EN)
		else $error("32 kHz on battery");
	a_pwrup_clear: assert property ($rose(st == PWR_REC) |-> !ctrl.osc_fail_irq_en && !ctrl.backup_irq_en)
		else $error("enables survive power-up");
	a_ht_tamper: assert property (st == PWR_ON && !vcc && ctrl.tamper_en_a && !ctrl.halt_update
		|=> !ctrl.halt_update) else $error("halt-update set with tamper");

	c_osc_irq: cover property (irq_act ##1 IRQ_OUT_OE);
	c_rec_done: cover property (st == PWR_REC ##1 st == PWR_ON);
	c_reject: cover property (BVALID && BRESP == `ROFD_RESP_SLV);
endmodule // rofd_ctl

// ==== rofd_env.sv ====
// Supply and oscillator monitors plus the pulled-up interrupt pin.
// Assumes the bench commands supply and oscillator state.
`timescale 1ns/1ps
module rofd_env (
	// Bench requests
	input  wire logic vcc_req,
	input  wire logic osc_req,
	// Device pin
	input  wire logic IRQ_OUT_O,
	input  wire logic IRQ_OUT_OE,
	// Monitors and pin level
	output logic      VCC_OK,
	output logic      OSC_RUN,
	output logic      irq_pin_n
);
	// Unrelated in phase to the core clock
	assign #37 VCC_OK = vcc_req;
	assign #23 OSC_RUN = osc_req;
	// Pull-up holds the pin high when released
	assign irq_pin_n = IRQ_OUT_OE ? IRQ_OUT_O : 1'b1;
endmodule // rofd_env

// ==== tb_top.sv ====
// Register-level tests of the supervisor slice.
// Assumes rofd_ctl, rofd_env and AXI4-Lite ports.
`timescale 1ns/1ps
module tb_top;
	localparam logic [55:0] SN      = 56'h1234_5678_9abc_de; // Arbitrary value
	localparam int          REC_DEF = 40;
	localparam int          REC_ST  = 20;
	localparam logic [1:0]  OK      = 2'b00;
	localparam logic [1:0]  SLV     = 2'b10;
	localparam logic [1:0]  DEC     = 2'b11;
	localparam logic [7:0]  PAR     = SN[55:48] ^ SN[47:40] ^ SN[39:32] ^ SN[31:24] ^ SN[23:16] ^ SN[15:8] ^ SN[7:0];
	logic        CORE_CLK = 1'b0;
	logic        SYS_RST  = 1'b1;
	logic [7:0]  AWADDR   = 8'h00;
	logic [7:0]  ARADDR   = 8'h00;
	logic [31:0] WDATA    = 32'h0;
	logic [3:0]  WSTRB    = 4'hf;
	logic        AWVALID  = 1'b0;
	logic        WVALID   = 1'b0;
	logic        BREADY   = 1'b0;
	logic        ARVALID  = 1'b0;
	logic        RREADY   = 1'b0;
	logic        vcc_req  = 1'b1;
	logic        osc_req  = 1'b1;
	logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, VCC_OK, OSC_RUN;
	logic        IRQ_OUT_O, IRQ_OUT_OE, KHZ32_EN, RST_ACT, WR_PROTECT, IRQ, irq_pin_n;
	logic [1:0]  BRESP, RRESP;
	logic [31:0] RDATA;
	logic [31:0] lc [6] = '{32'h00, 32'h10, 32'h20, 32'h30, 32'h10, 32'h00};
	logic [31:0] ly [6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h4, 32'h5};
	logic [31:0] le [6] = '{32'h100, 32'h0, 32'h0, 32'h0, 32'h104, 32'h5};
	int          n_errors = 0;
	int          cmp_count = 0;
	int          n, i;

	always #50 CORE_CLK = ~CORE_CLK;

	rofd_ctl #(.REC_DEF_CYC(REC_DEF), .REC_ST_CYC(REC_ST), .SERIAL_NUM(SN)) u_rofd_ctl (
		.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST),
		.AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
		.WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
		.BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
		.ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
		.RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
		.VCC_OK(VCC_OK), .OSC_RUN(OSC_RUN), .IRQ_OUT_O(IRQ_OUT_O), .IRQ_OUT_OE(IRQ_OUT_OE),
		.KHZ32_EN(KHZ32_EN), .RST_ACT(RST_ACT), .WR_PROTECT(WR_PROTECT), .IRQ(IRQ)
	);

	rofd_env u_rofd_env (
		.vcc_req(vcc_req), .osc_req(osc_req), .IRQ_OUT_O(IRQ_OUT_O), .IRQ_OUT_OE(IRQ_OUT_OE),
		.VCC_OK(VCC_OK), .OSC_RUN(OSC_RUN), .irq_pin_n(irq_pin_n)
	);

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic stop_test;
		$display("errors %0d comparisons %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch at %0t: got %h exp %h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int t;
		@(posedge CORE_CLK);
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		t = 0;
		do begin
			@(posedge CORE_CLK);
			if (AWREADY === 1'b1) AWVALID <= 1'b0;
			if (WREADY === 1'b1) WVALID <= 1'b0;
			t++;
		end while (BVALID !== 1'b1 && t < 1000);
		BREADY <= 1'b0;
		chk(BVALID, 32'h1);
		chk(BRESP, er);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		int t;
		@(posedge CORE_CLK);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		t = 0;
		do begin
			@(posedge CORE_CLK);
			if (ARREADY === 1'b1) ARVALID <= 1'b0;
			t++;
		end while (RVALID !== 1'b1 && t < 1000);
		RREADY <= 1'b0;
		chk(RVALID, 32'h1);
		chk(RDATA, e);
		chk(RRESP, er);
	endtask

	// Power cycle with given control and clock values
	task automatic pwr(input logic [31:0] c, input logic [31:0] k, input logic [31:0] e, input logic p, input int rec);
		wr(8'h04, k, OK);
		wr(8'h00, c, OK);
		vcc_req <= 1'b0;
		repeat (10) @(posedge CORE_CLK);
		chk(KHZ32_EN, 32'h0);
		chk(irq_pin_n, p);
		chk(RST_ACT, 32'h1);
		wr(8'h00, 32'h0, SLV);
		vcc_req <= 1'b1;
		for (n = 0; n < 1000 && WR_PROTECT !== 1'b0; n++) @(posedge CORE_CLK);
		chk(n >= rec && n <= rec + 12, 32'h1);
		chk(RST_ACT, 32'h0);
		rd(8'h18, 32'h2, OK);
		wr(8'h18, 32'h2, OK);
		rd(8'h00, e, OK);
		rd(8'h04, k, OK);
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge CORE_CLK);
		SYS_RST <= 1'b0;
		repeat (2) @(posedge CORE_CLK);
		rd(8'h00, 32'hf8, OK);
		rd(8'h04, 32'h0, OK);
		rd(8'h08, 32'h1, OK);
		chk(KHZ32_EN, 32'h1);
		rd(8'h20, 32'h0, DEC);
		wr(8'h10, 32'hffffffff, DEC);
		wr(8'h14, 32'h0, DEC);
		rd(8'h10, SN[31:0], OK);
		rd(8'h14, {PAR, SN[55:32]}, OK);
		wr(8'h00, 32'hfa, OK);
		repeat (3) @(posedge CORE_CLK);
		chk(irq_pin_n, 32'h0);
		rd(8'h08, 32'h1, OK);
		chk(irq_pin_n, 32'h0);
		wr(8'h08, 32'h0, OK);
		repeat (3) @(posedge CORE_CLK);
		chk(irq_pin_n, 32'h1);
		wr(8'h1c, 32'h1, OK);
		osc_req <= 1'b0;
		repeat (10) @(posedge CORE_CLK);
		chk(irq_pin_n, 32'h0);
		chk(IRQ, 32'h1);
		osc_req <= 1'b1;
		repeat (10) @(posedge CORE_CLK);
		rd(8'h08, 32'h1, OK);
		wr(8'h00, 32'hf8, OK);
		repeat (3) @(posedge CORE_CLK);
		chk(irq_pin_n, 32'h1);
		wr(8'h18, 32'h1, OK);
		repeat (3) @(posedge CORE_CLK);
		chk(IRQ, 32'h0);
		wr(8'h08, 32'h0, OK);
		rd(8'h08, 32'h0, OK);
		wr(8'h00, 32'hf9, OK);
		rd(8'h08, 32'h1, OK);
		wr(8'h1c, 32'h0, OK);
		wr(8'h18, 32'h3, OK);
		for (i = 0; i < 6; i++) begin
			wr(8'h04, lc[i], OK);
			wr(8'h0c, ly[i], OK);
			rd(8'h0c, le[i], OK);
		end
		pwr(32'hf7, 32'h00, 32'hf9, 1'b0, REC_ST);
		pwr(32'hf3, 32'h00, 32'hf9, 1'b1, REC_ST);
		pwr(32'h2f0, 32'h00, 32'h2f0, 1'b1, REC_DEF);
		pwr(32'hf0, 32'h80, 32'hf8, 1'b1, 500);
		stop_test;
	end

	initial begin
		repeat (20000) @(posedge CORE_CLK);
		n_errors++;
		stop_test;
	end
endmodule // tb_top
